// ### hdl/ehf_pkg.sv
// ehf_pkg: constants for the endpoint handshake flag block
// assumes a 32-bit classic wishbone slave, word-aligned registers
package ehf_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_STATUS = 8'h00;  // endpoint_handshake_status
   localparam logic [7:0] ADDR_CTRL = 8'h04;    // endpoint type: control and iso bits
   localparam logic [7:0] ADDR_EVENT = 8'h08;   // latched last usb engine events, read only
   // status field positions
   localparam int BIT_CWR_ACCEPT = 7;
   localparam int BIT_DATA_END = 6;
   localparam int BIT_TX_READY = 4;
   localparam int BIT_STALL_SENT = 3;
   localparam int BIT_SETUP_RCVD = 2;
   localparam int BIT_OUT_STORED = 1;
   localparam int BIT_TX_DONE = 0;
   // ctrl field positions
   localparam int CTRL_IS_CONTROL = 0;
   localparam int CTRL_IS_ISO = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // handshake codes toward the link
   typedef enum logic [1:0] {EHF_HS_NONE, EHF_HS_ACK, EHF_HS_NAK, EHF_HS_STALL} ehf_hs_t;
endpackage

// ### hdl/ehf_pulse_reg.sv
// ehf_pulse_reg: one registered pulse output with synchronous clear
// assumes one clock domain, sync active-high reset
`timescale 1ns/100ps
`default_nettype none
module ehf_pulse_reg (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   output logic q_o
);
   logic q_nxt;
   // next value is simply the request
   always_comb begin
      q_nxt = set_i;
   end
   // register stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= 1'b0;
      end else begin
         q_o <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// ### hdl/ehf_top.sv
// ehf_top: per-endpoint handshake flags with wishbone register access
// assumes the usb engine sends same-clock one-cycle event pulses
// Behaviour
// RL1 - clear tx-ready when host acknowledges the transmitted packet
// RL2 - on iso endpoint clear tx-ready once data sent, no ack
// RL3 - firmware fills fifo only while tx-ready clear, then sets it
// RL4 - a zero byte loaded packet is sent as valid empty data
// RL5 - on control endpoint firmware writes fifo only when requested
// RL6 - hardware clearing tx-ready raises interrupt when enabled
// RL7 - status phase IN with DATA1 when tx-ready 0 and data-end 1
// RL8 - set stall-sent flag after a STALL handshake goes out
// RL9 - set setup-received flag when valid setup stored on control endpoint
// RL10 - setting setup-received clears every other status bit
// RL11 - setup-received raises interrupt when enabled
// RL12 - firmware clears setup-received after reading setup data
// RL13 - set out-stored flag after OUT data stored in fifo
// RL14 - while out-stored set, NAK every OUT token
// RL15 - control endpoint accepts OUT data only with control-write-accept set
// RL16 - never overwrite unread fifo data except by early setup
// RL17 - setting out-stored raises interrupt when enabled
// RL18 - firmware clears out-stored after reading fifo
// RL19 - control status-phase OUT DATA1 also uses out-stored flag
// RL20 - data-end with tx-ready enters status phase after packet sent
// RL21 - each interrupt gated by its outside enable; flags reset zero
`timescale 1ns/100ps
`default_nettype none
module ehf_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // usb engine events, one-cycle pulses
   input wire logic in_token_i,
   input wire logic in_sent_i,
   input wire logic host_ack_i,
   input wire logic stall_sent_i,
   input wire logic setup_stored_i,
   input wire logic out_token_i,
   input wire logic out_stored_i,
   // interrupt enables held elsewhere
   input wire logic ie_tx_i,
   input wire logic ie_setup_i,
   input wire logic ie_out_i,
   // answers to the usb engine
   output logic [1:0] in_hs_o,
   output logic in_send_data_o,
   output logic in_data1_o,
   output logic [1:0] out_hs_o,
   output logic out_accept_o,
   output logic status_phase_o,
   output logic irq_tx_o,
   output logic irq_setup_o,
   output logic irq_out_o
);
   logic [7:0] status_r, status_nxt;
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic ack_r, ack_nxt;
   logic [1:0] in_hs_r, in_hs_nxt, out_hs_r, out_hs_nxt;
   logic in_send_r, in_send_nxt, in_d1_r, in_d1_nxt;
   logic out_acc_r, out_acc_nxt, stat_ph_r, stat_ph_nxt;
   logic [3:0] last_ev_r, last_ev_nxt;
   logic wr, wr_lane0, is_ctl, is_iso;
   logic tx_clr_hw, setup_set, out_set, tx_irq_req, setup_irq_req, out_irq_req;

   assign is_ctl = ctrl_r[ehf_pkg::CTRL_IS_CONTROL];
   assign is_iso = ctrl_r[ehf_pkg::CTRL_IS_ISO];
   assign wr = cyc_i && stb_i && we_i && ack_r;  // lands on the edge where the master sees ack
   assign wr_lane0 = wr && sel_i[0];

   // flag events; setup only counts on control endpoints
   always_comb begin
      setup_set = setup_stored_i && is_ctl;  // see RL9
      // iso drops the flag on send, others wait for the host ack
      tx_clr_hw = status_r[ehf_pkg::BIT_TX_READY] &&
         (is_iso ? in_sent_i : host_ack_i);  // see RL1 see RL2
      // out data is only stored when the fifo holds nothing unread
      out_set = out_stored_i && !status_r[ehf_pkg::BIT_OUT_STORED] &&
         (!is_ctl || status_r[ehf_pkg::BIT_CWR_ACCEPT]);  // see RL13 see RL15 see RL16 see RL19
      tx_irq_req = tx_clr_hw && ie_tx_i;  // see RL6 see RL21
      setup_irq_req = setup_set && ie_setup_i;  // see RL11 see RL21
      out_irq_req = out_set && ie_out_i;  // see RL17 see RL21
   end

   // status register: firmware writes, hardware events win over them, early setup wins over all
   always_comb begin
      status_nxt = status_r;
      ctrl_nxt = ctrl_r;
      if (wr_lane0 && adr_i == ehf_pkg::ADDR_STATUS) begin
         // firmware may set tx-ready and control bits, and clear rx flags
         status_nxt = dat_i[7:0];  // see RL3 see RL12 see RL18
      end
      if (wr_lane0 && adr_i == ehf_pkg::ADDR_CTRL) begin
         ctrl_nxt = dat_i[1:0];
      end
      if (tx_clr_hw) begin
         status_nxt[ehf_pkg::BIT_TX_READY] = 1'b0;  // see RL1
      end
      if (stall_sent_i) begin
         status_nxt[ehf_pkg::BIT_STALL_SENT] = 1'b1;  // see RL8
      end
      if (out_set) begin
         status_nxt[ehf_pkg::BIT_OUT_STORED] = 1'b1;  // see RL13
      end
      // early setup overrides everything, including unread out data
      if (setup_set) begin
         status_nxt = ehf_pkg::STATUS_RESET;  // see RL10 see RL16
         status_nxt[ehf_pkg::BIT_SETUP_RCVD] = 1'b1;  // see RL9
      end
   end

   // token answers toward the serial engine
   always_comb begin
      in_hs_nxt = ehf_pkg::EHF_HS_NONE;
      in_send_nxt = 1'b0;
      in_d1_nxt = 1'b0;
      out_hs_nxt = ehf_pkg::EHF_HS_NONE;
      out_acc_nxt = 1'b0;
      stat_ph_nxt = is_ctl && status_r[ehf_pkg::BIT_DATA_END] &&
         !status_r[ehf_pkg::BIT_TX_READY];  // see RL20
      if (in_token_i) begin
         if (status_r[ehf_pkg::BIT_TX_READY]) begin
            in_send_nxt = 1'b1;  // length may be zero, still valid data, see RL4
         end else if (is_ctl && status_r[ehf_pkg::BIT_DATA_END]) begin
            in_send_nxt = 1'b1;  // empty DATA1 status packet, see RL7
            in_d1_nxt = 1'b1;
         end else begin
            in_hs_nxt = ehf_pkg::EHF_HS_NAK;
         end
      end
      if (out_token_i) begin
         if (status_r[ehf_pkg::BIT_OUT_STORED] ||
            (is_ctl && !status_r[ehf_pkg::BIT_CWR_ACCEPT])) begin
            out_hs_nxt = ehf_pkg::EHF_HS_NAK;  // see RL14 see RL15
         end else begin
            out_hs_nxt = ehf_pkg::EHF_HS_ACK;
            out_acc_nxt = 1'b1;
         end
      end
      last_ev_nxt = last_ev_r;
      if (host_ack_i || in_sent_i || stall_sent_i || out_token_i) begin
         last_ev_nxt = {host_ack_i, in_sent_i, stall_sent_i, out_token_i};
      end
   end

   // bus slave: one wait state, unmapped reads give zero
   always_comb begin
      ack_nxt = cyc_i && stb_i && !ack_r;
      dat_nxt = 32'h0000_0000;
      if (cyc_i && stb_i && !we_i && !ack_r) begin
         case (adr_i)
            ehf_pkg::ADDR_STATUS: dat_nxt = {24'h00_0000, status_r};
            ehf_pkg::ADDR_CTRL: dat_nxt = {30'h0000_0000, ctrl_r};
            ehf_pkg::ADDR_EVENT: dat_nxt = {28'h000_0000, last_ev_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   // status and control group registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= ehf_pkg::STATUS_RESET;  // see RL21
         ctrl_r <= ehf_pkg::CTRL_RESET;
      end else begin
         status_r <= status_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // bus answer group registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
         ack_r <= 1'b0;
      end else begin
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
      end
   end

   // token answer group registers, with the last-event record
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_hs_r <= ehf_pkg::EHF_HS_NONE;
         out_hs_r <= ehf_pkg::EHF_HS_NONE;
         in_send_r <= 1'b0;
         in_d1_r <= 1'b0;
         out_acc_r <= 1'b0;
         stat_ph_r <= 1'b0;
         last_ev_r <= 4'h0;
      end else begin
         in_hs_r <= in_hs_nxt;
         out_hs_r <= out_hs_nxt;
         in_send_r <= in_send_nxt;
         in_d1_r <= in_d1_nxt;
         out_acc_r <= out_acc_nxt;
         stat_ph_r <= stat_ph_nxt;
         last_ev_r <= last_ev_nxt;
      end
   end

   // interrupt pulses come out of a register each
   ehf_pulse_reg u_irq_tx (.clk_i(clk_i), .rst_i(rst_i), .set_i(tx_irq_req), .q_o(irq_tx_o));
   ehf_pulse_reg u_irq_setup (.clk_i(clk_i), .rst_i(rst_i), .set_i(setup_irq_req),
      .q_o(irq_setup_o));
   ehf_pulse_reg u_irq_out (.clk_i(clk_i), .rst_i(rst_i), .set_i(out_irq_req), .q_o(irq_out_o));

   assign dat_o = dat_r;
   assign ack_o = ack_r;
   assign in_hs_o = in_hs_r;
   assign in_send_data_o = in_send_r;
   assign in_data1_o = in_d1_r;
   assign out_hs_o = out_hs_r;
   assign out_accept_o = out_acc_r;
   assign status_phase_o = stat_ph_r;
endmodule
`default_nettype wire

// ### tb/ehf_top_properties.sv
// checker: handshake flag timing seen at the ehf_top ports
// assumes it is bound onto ehf_top, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module ehf_top_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic in_sent_i,
   input wire logic host_ack_i,
   input wire logic setup_stored_i,
   input wire logic out_token_i,
   input wire logic out_stored_i,
   input wire logic ie_tx_i,
   input wire logic ie_setup_i,
   input wire logic ie_out_i,
   input wire logic in_send_data_o,
   input wire logic in_data1_o,
   input wire logic [1:0] out_hs_o,
   input wire logic out_accept_o,
   input wire logic irq_tx_o,
   input wire logic irq_setup_o,
   input wire logic irq_out_o
);
   logic full_r;
   logic full_nxt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // out flag mirror; any bus cycle may clear it, so drop it then
   always_comb begin
      full_nxt = full_r | irq_out_o;
      if (cyc_i || setup_stored_i || rst_i) begin
         full_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      full_r <= full_nxt;
   end
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   ack_resp_a: assert property (req_s |=> ack_o) else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   out_full_nak_a: assert property (full_r && out_token_i |=>
      out_hs_o == ehf_pkg::EHF_HS_NAK) else $error("out not refused");
   out_answer_a: assert property (out_token_i |=> out_hs_o != ehf_pkg::EHF_HS_NONE
      && out_accept_o == (out_hs_o == ehf_pkg::EHF_HS_ACK)) else $error("bad out answer");
   irq_out_a: assert property (irq_out_o |-> $past(out_stored_i) && $past(ie_out_i))
      else $error("stray out irq");
   irq_setup_a: assert property (irq_setup_o |-> $past(setup_stored_i)
      && $past(ie_setup_i)) else $error("stray setup irq");
   irq_tx_a: assert property (irq_tx_o |-> $past(ie_tx_i)
      && ($past(in_sent_i) || $past(host_ack_i))) else $error("stray tx irq");
   data1_send_a: assert property (in_data1_o |-> in_send_data_o) else $error("lone data1");
endmodule
bind ehf_top ehf_top_properties u_ehf_top_properties (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .in_sent_i(in_sent_i), .host_ack_i(host_ack_i),
   .setup_stored_i(setup_stored_i), .out_token_i(out_token_i), .out_stored_i(out_stored_i),
   .ie_tx_i(ie_tx_i), .ie_setup_i(ie_setup_i), .ie_out_i(ie_out_i),
   .in_send_data_o(in_send_data_o), .in_data1_o(in_data1_o), .out_hs_o(out_hs_o),
   .out_accept_o(out_accept_o), .irq_tx_o(irq_tx_o), .irq_setup_o(irq_setup_o),
   .irq_out_o(irq_out_o));
`default_nettype wire

// ### tb/ehf_usb_model.sv
// usb engine stand-in: bench requests become one-cycle event pulses
// assumes the bench raises each request for one cycle only
`timescale 1ns/100ps
`default_nettype none
module ehf_usb_model (
   input wire logic clk_i,
   input wire logic [6:0] req_i,
   output logic [6:0] ev_o = 7'h00
);
   // registered so each event is a clean same-clock pulse
   always_ff @(posedge clk_i) begin
      ev_o <= req_i;
   end
endmodule
`default_nettype wire

// ### tb/ehf_top_tb_top.sv
// bench for ehf_top: bus tasks, usb events, random tx rounds
// assumes ehf_pkg, the model and the checker compiled first
`timescale 1ns/100ps
`default_nettype none
module ehf_top_tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0] adr_i = 8'h00, q;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, snd, d1, sph, itx, isu, iout, acc, iso;
   logic ie_tx = 0, ie_su = 0, ie_out = 0;
   logic [1:0] ihs, ohs;
   logic [6:0] req = 7'h00, ev;
   integer num_errors = 0, cmp_count = 0, seed = 63, tick = 0, k;
   always #5 clk_i = ~clk_i;
   ehf_usb_model u_ehf_usb_model (.clk_i(clk_i), .req_i(req), .ev_o(ev));
   ehf_top u_ehf_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .in_token_i(ev[0]), .in_sent_i(ev[1]), .host_ack_i(ev[2]), .stall_sent_i(ev[3]),
      .setup_stored_i(ev[4]), .out_token_i(ev[5]), .out_stored_i(ev[6]), .ie_tx_i(ie_tx),
      .ie_setup_i(ie_su), .ie_out_i(ie_out), .in_hs_o(ihs), .in_send_data_o(snd),
      .in_data1_o(d1), .out_hs_o(ohs), .out_accept_o(acc), .status_phase_o(sph),
      .irq_tx_o(itx), .irq_setup_o(isu), .irq_out_o(iout));
   task automatic final_report();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // classic cycle; holds everything until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      adr_i <= a;
      dat_i <= {24'h0, d};
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o[7:0];
      {cyc_i, stb_i} <= 2'b00;
   endtask
   // one event; returns when its answers stand
   task automatic ev_go(input logic [6:0] v);
      @(posedge clk_i);
      req <= v;
      @(posedge clk_i);
      req <= 7'h00;
      @(posedge clk_i);
      #1;
   endtask
   function automatic logic [7:0] hs_exp(input logic full);
      return full ? 8'(ehf_pkg::EHF_HS_NAK) : 8'(ehf_pkg::EHF_HS_ACK);
   endfunction
   // hang guard; the run needs well under a thousand cycles
   always @(posedge clk_i) begin
      tick++;
      if (tick == 5000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, ehf_pkg::ADDR_STATUS, 8'h00);
      chk(q, ehf_pkg::STATUS_RESET);
      wb(0, 8'h0C, 8'h00);
      chk(q, 8'h00);
      ev_go(7'h08);
      wb(0, ehf_pkg::ADDR_STATUS, 8'h00);
      chk(q, 8'h08);
      wb(1, ehf_pkg::ADDR_CTRL, 8'h01);
      ie_out <= 1'b1;
      ev_go(7'h40);
      chk(8'(iout), 8'h00);
      wb(1, ehf_pkg::ADDR_STATUS, 8'h80);
      ev_go(7'h20);
      chk(8'(ohs), hs_exp(0));
      chk(8'(acc), 8'h01);
      ev_go(7'h40);
      chk(8'(iout), 8'h01);
      ev_go(7'h20);
      chk(8'(ohs), hs_exp(1));
      chk(8'(acc), 8'h00);
      ev_go(7'h40);
      chk(8'(iout), 8'h00);
      wb(0, ehf_pkg::ADDR_STATUS, 8'h00);
      chk(q, 8'h82);
      wb(1, ehf_pkg::ADDR_STATUS, 8'h80);
      ev_go(7'h20);
      chk(8'(ohs), hs_exp(0));
      wb(1, ehf_pkg::ADDR_STATUS, 8'hDA);
      ie_su <= 1'b1;
      ev_go(7'h10);
      chk(8'(isu), 8'h01);
      wb(0, ehf_pkg::ADDR_STATUS, 8'h00);
      chk(q, 8'h04);
      wb(1, ehf_pkg::ADDR_STATUS, 8'h40);
      ev_go(7'h01);
      chk(8'({sph, snd, d1}), 8'h07);
      for (k = 0; k < 8; k++) begin
         iso = 1'($random(seed));
         wb(1, ehf_pkg::ADDR_CTRL, 8'({iso, 1'b0}));
         ie_tx <= 1'($random(seed));
         wb(1, ehf_pkg::ADDR_STATUS, 8'h10);
         ev_go(7'h01);
         chk(8'({snd, ihs}), 8'h04);
         ev_go(7'h02);
         chk(8'(itx), 8'(iso & ie_tx));
         wb(0, ehf_pkg::ADDR_STATUS, 8'h00);
         chk(q, iso ? 8'h00 : 8'h10);
         if (!iso) begin
            ev_go(7'h04);
            chk(8'(itx), 8'(ie_tx));
         end
      end
      // tx-ready now clear on a non-control endpoint, so an IN token is refused
      ev_go(7'h01);
      chk(8'({snd, ihs}), 8'h02);
      final_report();
   end
endmodule
`default_nettype wire
